// file: ssp_pkg.sv
// ssp_pkg: constants and field layouts for the three-wire synthesizer programming port
// assumes: included before every other design file of the port
package ssp_pkg;

	localparam int unsigned SSP_WORD_W  = 22;
	localparam int unsigned SSP_DATA_W  = 20;
	localparam int unsigned SSP_ADDR_W  = 2;
	localparam int unsigned SSP_LATCH_N = 4;
	localparam int unsigned SSP_SYNC_N  = 3;

	// positions inside the 22-bit shift word
	localparam int unsigned SSP_DATA_MSB = 21;
	localparam int unsigned SSP_DATA_LSB = 2;
	localparam int unsigned SSP_ADDR_MSB = 1;

	// latch selection codes
	localparam logic [1:0] SSP_ADR_SECOND_REF = 2'h0;
	localparam logic [1:0] SSP_ADR_SECOND_FB  = 2'h1;
	localparam logic [1:0] SSP_ADR_FIRST_REF  = 2'h2;
	localparam logic [1:0] SSP_ADR_FIRST_FB   = 2'h3;

	// values after reset
	localparam logic [21:0] SSP_SHIFT_RST = 22'h000000;
	localparam logic [19:0] SSP_LATCH_RST = 20'h00000;

	// reference-divider latch layout, data bits 19..0 = word bits 21..2
	typedef struct packed {
		logic [1:0]  multifunction_output_select;
		logic        pump_tristate;
		logic        pump_high_current;
		logic        detector_polarity;
		logic [14:0] reference_ratio;
	} ssp_ref_s;

	// feedback-divider latch layout
	typedef struct packed {
		logic        loop_power_down;
		logic        prescaler_modulus;
		logic [12:0] program_count;
		logic [4:0]  swallow_count;
	} ssp_fb_s;

	// serial pin group as sampled
	typedef struct packed {
		logic sclk;
		logic sdata;
		logic load_strobe;
	} ssp_pins_s;

endpackage : ssp_pkg

// file: ssp_latch_bank.sv
// ssp_latch_bank: four 20-bit programming latches written through an address mux
// assumes: write strobe is a single-cycle pulse on clk
`timescale 1ns/10ps
`default_nettype none
module ssp_latch_bank
	import ssp_pkg::*;
#(
	parameter int unsigned DATA_W = SSP_DATA_W,
	parameter int unsigned ADDR_W = SSP_ADDR_W
) (
	input  wire logic                           clk,
	input  wire logic                           reset,
	input  wire logic                           ce,
	input  wire logic                           wr_en,
	input  wire logic [ADDR_W-1:0]              wr_addr,
	input  wire logic [DATA_W-1:0]              wr_data,
	output var  logic [(1<<ADDR_W)*DATA_W-1:0]  latch_q
);

	localparam int unsigned LN = 1 << ADDR_W;

	logic [DATA_W-1:0] mem_r   [LN];
	logic [DATA_W-1:0] mem_nxt [LN];

	////////////////////////////////////////////////////////////////////////////////
	genvar gi;
	generate
		for (gi = 0; gi < LN; gi++) begin : g_latch
			always_comb begin
				mem_nxt[gi] = mem_r[gi];
				if (wr_en && wr_addr == ADDR_W'(gi)) begin
					mem_nxt[gi] = wr_data;
				end
			end
			always_ff @(posedge clk) begin
				if (reset) begin
					mem_r[gi] <= SSP_LATCH_RST;
				end else if (ce) begin
					mem_r[gi] <= mem_nxt[gi];
				end
			end
			assign latch_q[gi*DATA_W +: DATA_W] = mem_r[gi];
		end
	endgenerate

endmodule : ssp_latch_bank
`default_nettype wire

// file: ssp_serial_port.sv
// ssp_serial_port: three-wire programming port with four divider latches
// assumes: serial pins are asynchronous to clk and much slower than it
`timescale 1ns/10ps
`default_nettype none
module ssp_serial_port
	import ssp_pkg::*;
#(
	parameter int unsigned WORD_W = SSP_WORD_W,
	parameter int unsigned SYNC_N = SSP_SYNC_N
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        ce,
	input  wire logic        sclk,
	input  wire logic        sdata,
	input  wire logic        load_strobe,
	output var  logic [1:0]  first_multifunction_output_select,
	output var  logic        first_pump_tristate,
	output var  logic        first_pump_high_current,
	output var  logic        first_detector_polarity,
	output var  logic [14:0] first_reference_ratio,
	output var  logic        first_loop_power_down,
	output var  logic        first_prescaler_modulus,
	output var  logic [12:0] first_program_count,
	output var  logic [4:0]  first_swallow_count,
	output var  logic [1:0]  second_multifunction_output_select,
	output var  logic        second_pump_tristate,
	output var  logic        second_pump_high_current,
	output var  logic        second_detector_polarity,
	output var  logic [14:0] second_reference_ratio,
	output var  logic        second_loop_power_down,
	output var  logic        second_prescaler_modulus,
	output var  logic [12:0] second_program_count,
	output var  logic [4:0]  second_swallow_count
);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: three stages, change accepted when stages 2 and 3 agree
	ssp_pins_s sync1_r, sync2_r, sync3_r;
	ssp_pins_s sync1_nxt, sync2_nxt, sync3_nxt;
	ssp_pins_s pins_in;
	ssp_pins_s stable_r, stable_nxt;

	always_comb begin
		pins_in   = '{sclk: sclk, sdata: sdata, load_strobe: load_strobe};
		sync1_nxt = pins_in;
		sync2_nxt = sync1_r;
		sync3_nxt = sync2_r;
		stable_nxt = stable_r;
		if (sync2_r.sclk == sync3_r.sclk) begin
			stable_nxt.sclk = sync3_r.sclk;
		end
		if (sync2_r.sdata == sync3_r.sdata) begin
			stable_nxt.sdata = sync3_r.sdata;
		end
		if (sync2_r.load_strobe == sync3_r.load_strobe) begin
			stable_nxt.load_strobe = sync3_r.load_strobe;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sync1_r  <= '0;
			sync2_r  <= '0;
			sync3_r  <= '0;
			stable_r <= '0;
		end else if (ce) begin
			sync1_r  <= sync1_nxt;
			sync2_r  <= sync2_nxt;
			sync3_r  <= sync3_nxt;
			stable_r <= stable_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// edge detection and shift register
	logic              sclk_rise, strobe_rise;
	logic [WORD_W-1:0] shift_r, shift_nxt;
	logic              load_r, load_nxt;

	always_comb begin
		sclk_rise = stable_nxt.sclk & ~stable_r.sclk;
		strobe_rise = stable_nxt.load_strobe & ~stable_r.load_strobe;
		shift_nxt = shift_r;
		if (sclk_rise) begin
			shift_nxt = {shift_r[WORD_W-2:0], stable_nxt.sdata};
		end
		load_nxt = strobe_rise;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			shift_r <= SSP_SHIFT_RST;
			load_r  <= 1'b0;
		end else if (ce) begin
			shift_r <= shift_nxt;
			load_r  <= load_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// latches: written regardless of power-down bits
	logic [SSP_LATCH_N*SSP_DATA_W-1:0] latch_q;

	ssp_latch_bank #(
		.DATA_W (SSP_DATA_W),
		.ADDR_W (SSP_ADDR_W)
	) u_bank (
		.clk     (clk),
		.reset   (reset),
		.ce      (ce),
		.wr_en   (load_r),
		.wr_addr (shift_r[SSP_ADDR_MSB:0]),
		.wr_data (shift_r[SSP_DATA_MSB:SSP_DATA_LSB]),
		.latch_q (latch_q)
	);

	////////////////////////////////////////////////////////////////////////////////
	// field split; latch outputs are flip-flops
	ssp_ref_s first_ref, second_ref;
	ssp_fb_s  first_fb, second_fb;

	always_comb begin
		second_ref = ssp_ref_s'(latch_q[SSP_ADR_SECOND_REF*SSP_DATA_W +: SSP_DATA_W]);
		second_fb  = ssp_fb_s'(latch_q[SSP_ADR_SECOND_FB*SSP_DATA_W +: SSP_DATA_W]);
		first_ref  = ssp_ref_s'(latch_q[SSP_ADR_FIRST_REF*SSP_DATA_W +: SSP_DATA_W]);
		first_fb   = ssp_fb_s'(latch_q[SSP_ADR_FIRST_FB*SSP_DATA_W +: SSP_DATA_W]);
		first_multifunction_output_select  = first_ref.multifunction_output_select;
		first_pump_tristate                = first_ref.pump_tristate;
		first_pump_high_current            = first_ref.pump_high_current;
		first_detector_polarity            = first_ref.detector_polarity;
		first_reference_ratio              = first_ref.reference_ratio;
		first_loop_power_down              = first_fb.loop_power_down;
		first_prescaler_modulus            = first_fb.prescaler_modulus;
		first_program_count                = first_fb.program_count;
		first_swallow_count                = first_fb.swallow_count;
		second_multifunction_output_select = second_ref.multifunction_output_select;
		second_pump_tristate               = second_ref.pump_tristate;
		second_pump_high_current           = second_ref.pump_high_current;
		second_detector_polarity           = second_ref.detector_polarity;
		second_reference_ratio             = second_ref.reference_ratio;
		second_loop_power_down             = second_fb.loop_power_down;
		second_prescaler_modulus           = second_fb.prescaler_modulus;
		second_program_count               = second_fb.program_count;
		second_swallow_count               = second_fb.swallow_count;
	end

endmodule : ssp_serial_port
`default_nettype wire

// file: ssp_serial_port_checker.sv
// ssp_serial_port_checker: port assertions for the programming port
// assumes: bound to ssp_serial_port, pins driven off clk by a slow controller
`timescale 1ns/10ps
`default_nettype none
module ssp_serial_port_checker (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        ce,
	input wire logic        load_strobe,
	input wire logic [14:0] first_reference_ratio,
	input wire logic [12:0] first_program_count,
	input wire logic [14:0] second_reference_ratio,
	input wire logic [4:0]  second_swallow_count
);
	logic       ls_r,  ls_nxt;
	logic [3:0] age_r, age_nxt;
	// age: cycles since the strobe pin rose, saturating
	always_comb begin
		ls_nxt  = reset ? 1'b0 : load_strobe;
		age_nxt = (load_strobe && !ls_r) ? 4'h1 : age_r + {3'h0, age_r != 4'hf};
		if (reset)
			age_nxt = 4'hf;
	end
	always_ff @(posedge clk) begin
		ls_r  <= ls_nxt;
		age_r <= age_nxt;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_recent; age_r >= 4'h3 && age_r <= 4'h8; endsequence
	sequence s_held; $stable(second_reference_ratio) [*2]; endsequence
	property p_fref; !$stable(first_reference_ratio) |-> s_recent; endproperty
	property p_fprog; !$stable(first_program_count) |-> s_recent; endproperty
	property p_sref; !$stable(second_reference_ratio) |-> s_recent; endproperty
	property p_sswal; !$stable(second_swallow_count) |-> s_recent; endproperty
	property p_early; $rose(load_strobe) |=> s_held; endproperty
	property p_quiet; age_r == 4'hf |-> $stable(first_program_count); endproperty
	property p_freeze; !ce |=> $stable(first_reference_ratio); endproperty
	property p_reset;
		disable iff (1'b0) reset && ce |=> first_reference_ratio == 15'h0;
	endproperty
	a_fref: assert property (p_fref) else $error("first ref moved without load");
	a_fprog: assert property (p_fprog) else $error("first fb moved without load");
	a_sref: assert property (p_sref) else $error("second ref moved without load");
	a_sswal: assert property (p_sswal) else $error("second fb moved without load");
	a_early: assert property (p_early) else $error("latch moved too early");
	a_quiet: assert property (p_quiet) else $error("latch moved while idle");
	a_freeze: assert property (p_freeze) else $error("latch moved with ce low");
	a_reset: assert property (p_reset) else $error("latch not cleared by reset");
endmodule : ssp_serial_port_checker
bind ssp_serial_port ssp_serial_port_checker i_ssp_serial_port_checker (
	.clk(clk), .reset(reset), .ce(ce), .load_strobe(load_strobe),
	.first_reference_ratio(first_reference_ratio), .first_program_count(first_program_count),
	.second_reference_ratio(second_reference_ratio),
	.second_swallow_count(second_swallow_count)
);
`default_nettype wire

// file: ssp_ctrl_model.sv
// ssp_ctrl_model: serial controller driving the three programming pins
// assumes: sclk and load_strobe idle low, sdata left at the inverse of the last bit, link clock period 64 ns times the speed factor
`timescale 1ns/10ps
`default_nettype none
module ssp_ctrl_model (
	output var logic sclk,
	output var logic sdata,
	output var logic load_strobe
);
	initial begin
		sclk        = 1'b0;
		sdata       = 1'b0;
		load_strobe = 1'b0;
	end
	task automatic send_word(input logic [21:0] w, input logic ld, input int unsigned k);
		for (int i = 21; i >= 0; i--) begin
			sdata = w[i];
			#(32 * k) sclk = 1'b1;
			#(32 * k) sclk = 1'b0;
		end
		sdata = ~w[0];
		#(64 * k) load_strobe = ld;
		#(64 * k) load_strobe = 1'b0;
		#(64 * k);
	endtask : send_word
endmodule : ssp_ctrl_model
`default_nettype wire

// file: ssp_serial_port_test.sv
// ssp_serial_port_test: self-checking bench for the programming port
// assumes: ssp_ctrl_model drives the pins, clk 200 MHz
`timescale 1ns/10ps
`default_nettype none
module ssp_serial_port_test;
	logic        clk, reset, ce, sclk, sdata, load_strobe;
	wire  [19:0] lat [4];
	logic [19:0] exp [4];
	int          n_errors = 0, comparisons = 0;
	ssp_ctrl_model i_ssp_ctrl_model (.sclk(sclk), .sdata(sdata), .load_strobe(load_strobe));
	ssp_serial_port i_ssp_serial_port (.clk(clk), .reset(reset), .ce(ce), .sclk(sclk),
		.sdata(sdata), .load_strobe(load_strobe),
		.first_multifunction_output_select(lat[2][19:18]), .first_pump_tristate(lat[2][17]),
		.first_pump_high_current(lat[2][16]), .first_detector_polarity(lat[2][15]),
		.first_reference_ratio(lat[2][14:0]), .first_loop_power_down(lat[3][19]),
		.first_prescaler_modulus(lat[3][18]), .first_program_count(lat[3][17:5]),
		.first_swallow_count(lat[3][4:0]),
		.second_multifunction_output_select(lat[0][19:18]), .second_pump_tristate(lat[0][17]),
		.second_pump_high_current(lat[0][16]), .second_detector_polarity(lat[0][15]),
		.second_reference_ratio(lat[0][14:0]), .second_loop_power_down(lat[1][19]),
		.second_prescaler_modulus(lat[1][18]), .second_program_count(lat[1][17:5]),
		.second_swallow_count(lat[1][4:0]));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic check_all;
		for (int a = 0; a < 4; a++) begin
			comparisons++;
			if (lat[a] !== exp[a]) begin
				n_errors++;
				$display("CHECK FAILED %0t latch %0d mismatch", $time, a);
			end
		end
	endtask : check_all
	task automatic do_reset;
		@(posedge clk) #1 reset = 1'b1;
		repeat (10) @(posedge clk);
		#1 reset = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		exp = '{default: 20'h00000};
		check_all;
	endtask : do_reset
	task automatic load(input logic [21:0] w, input logic ld, input int unsigned k);
		i_ssp_ctrl_model.send_word(w, ld, k);
		if (ld)
			exp[w[1:0]] = w[21:2];
		check_all;
	endtask : load
	task automatic complete_run;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run
	initial begin
		reset = 1'b1;
		ce    = 1'b1;
		do_reset;
		load(22'h3fffff, 1'b1, 1);
		load(22'h2aaaa9, 1'b1, 2);
		load(22'h155556, 1'b1, 1);
		load(22'h0f0f0c, 1'b1, 1);
		load(22'h3c0003, 1'b0, 1);
		load(22'h123452, 1'b1, 1);
		@(posedge clk) #1 ce = 1'b0;
		i_ssp_ctrl_model.send_word(22'h0abcd2, 1'b1, 1);
		check_all;
		@(posedge clk) #1 ce = 1'b1;
		do_reset;
		load(22'h2468ad, 1'b1, 1);
		complete_run;
	end
	initial begin
		#100000;
		n_errors++;
		complete_run;
	end
endmodule : ssp_serial_port_test
`default_nettype wire
